// *** hdl/srp_pkg.sv ***
package srp_pkg;
    // Lane and burst layout
    localparam int LANE_W = 9;
    localparam int BURST_LEN = 4;
    localparam int BEAT_W = 2;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_STEP = 2'h1;
    localparam logic [1:0] BEAT_LAST = 2'h3;
    // Width variants
    localparam int DATA_W_X18 = 18;
    localparam int DATA_W_X36 = 36;
    localparam int ADDR_W_X18 = 19;
    localparam int ADDR_W_X36 = 18;
    // Link timing: clk_sys cycles per half period of the true input clock
    localparam int K_HALF_CYC = 1;
    // Write request buffer depth
    localparam int FIFO_DEPTH = 4;

    // Read port sequencer states
    typedef enum logic [2:0] {
        SRP_RD_IDLE = 3'b001,
        SRP_RD_WAIT = 3'b010,
        SRP_RD_BURST = 3'b100
    } srp_rd_state_e;

    // Write port sequencer states
    typedef enum logic [1:0] {
        SRP_WR_IDLE = 2'b01,
        SRP_WR_BURST = 2'b10
    } srp_wr_state_e;
endpackage

// *** hdl/srp_if.sv ***
`timescale 1ns/1ps
interface srp_if #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 18
);
    localparam int NB = DATA_W / 9;
    logic k_rise;
    logic kn_rise;
    logic write_port_choose_n;
    logic read_port_choose_n;
    logic [ADDR_W-1:0] addr;
    logic [NB-1:0] byte_lane_enable_n;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rdata_oe_n;

    modport memory (
        input k_rise,
        input kn_rise,
        input write_port_choose_n,
        input read_port_choose_n,
        input addr,
        input byte_lane_enable_n,
        input wdata,
        output rdata,
        output rdata_oe_n
    );

    modport controller (
        output k_rise,
        output kn_rise,
        output write_port_choose_n,
        output read_port_choose_n,
        output addr,
        output byte_lane_enable_n,
        output wdata,
        input rdata,
        input rdata_oe_n
    );
endinterface

// *** hdl/srp_fifo.sv ***
`timescale 1ns/1ps
module srp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic [PW:0] count_next;
    logic room_reg;
    logic empty_reg;
    wire push = in_valid && room_reg;
    wire pop = out_ready && !empty_reg;

    // Occupancy bookkeeping
    assign count_next = (push && !pop) ? count_reg + (PW+1)'(1) :
                        (pop && !push) ? count_reg - (PW+1)'(1) : count_reg;
    assign in_ready = room_reg;
    assign out_valid = !empty_reg;
    assign out_data = store[rd_ptr_reg];

    // Storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            store[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and flags
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            room_reg <= 1'b1;
            empty_reg <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PW'(1);
            end
            count_reg <= count_next;
            room_reg <= (count_next != CNT_FULL);
            empty_reg <= (count_next == '0);
        end
    end
endmodule

// *** hdl/srp_ctl_end.sv ***
`timescale 1ns/1ps
module srp_ctl_end
    import srp_pkg::*;
#(
    parameter int DATA_W = DATA_W_X36,
    parameter int ADDR_W = (DATA_W == DATA_W_X18) ? ADDR_W_X18 : ADDR_W_X36,
    parameter int K_HALF = K_HALF_CYC,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rstn,
    srp_if.controller link,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [BURST_LEN*DATA_W-1:0] wr_data,
    input wire logic [BURST_LEN*(DATA_W/LANE_W)-1:0] wr_be_n,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic rd_ack,
    output logic rd_word_valid,
    output logic [DATA_W-1:0] rd_word
);
    localparam int NB = DATA_W / LANE_W;
    localparam int BW = BURST_LEN * (DATA_W + NB);
    localparam int FW = ADDR_W + BW;
    localparam int CW = (K_HALF > 1) ? $clog2(K_HALF) : 1;
    localparam logic [CW-1:0] DIV_LAST = CW'(K_HALF - 1);

    logic [CW-1:0] div_cnt_reg;
    logic phase_reg;
    logic t_par_reg;
    logic k_rise_reg;
    logic kn_rise_reg;
    logic edge_d_reg;
    logic wsel_n_reg;
    logic rsel_n_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [NB-1:0] be_n_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [BW-1:0] burst_reg;
    logic [1:0] beat_reg;
    logic beat_on_reg;
    logic rd_ack_reg;
    logic rd_skip_reg;
    logic rd_vld_reg;
    logic [DATA_W-1:0] rd_word_reg;
    logic fifo_valid;
    logic [FW-1:0] fifo_data;

    // Edge slot scheduling: next cycle carries a true or complement edge
    wire edge_next = (div_cnt_reg == DIV_LAST);
    wire true_next = edge_next && phase_reg;
    // Writes go on even true edges, reads on odd ones, sharing one address bus
    wire wr_issue = true_next && !t_par_reg && fifo_valid && !beat_on_reg;
    wire rd_issue = true_next && t_par_reg && rd_req && !rd_ack_reg && !rd_skip_reg;
    wire beat_go = edge_next && beat_on_reg;
    wire [BW-1:0] burst_src = wr_issue ? fifo_data[BW-1:0] : burst_reg;
    wire [1:0] beat_use = wr_issue ? BEAT_FIRST : beat_reg;
    wire [DATA_W-1:0] word_sel = burst_src[beat_use*DATA_W +: DATA_W];
    wire [NB-1:0] be_sel = burst_src[BURST_LEN*DATA_W + beat_use*NB +: NB];

    srp_fifo #(
        .WIDTH(FW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data({wr_addr, wr_be_n, wr_data}),
        .out_valid(fifo_valid),
        .out_ready(wr_issue),
        .out_data(fifo_data)
    );

    assign link.k_rise = k_rise_reg;
    assign link.kn_rise = kn_rise_reg;
    assign link.write_port_choose_n = wsel_n_reg;
    assign link.read_port_choose_n = rsel_n_reg;
    assign link.addr = addr_reg;
    assign link.byte_lane_enable_n = be_n_reg;
    assign link.wdata = wdata_reg;
    assign rd_ack = rd_ack_reg;
    assign rd_word_valid = rd_vld_reg;
    assign rd_word = rd_word_reg;

    // Divider making alternating true and complement edge enables
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_cnt_reg <= '0;
            phase_reg <= 1'b1;
            t_par_reg <= 1'b0;
            k_rise_reg <= 1'b0;
            kn_rise_reg <= 1'b0;
            edge_d_reg <= 1'b0;
        end else begin
            div_cnt_reg <= edge_next ? '0 : div_cnt_reg + CW'(1);
            k_rise_reg <= true_next;
            kn_rise_reg <= edge_next && !phase_reg;
            edge_d_reg <= k_rise_reg || kn_rise_reg;
            if (edge_next) begin
                phase_reg <= !phase_reg;
            end
            if (true_next) begin
                t_par_reg <= !t_par_reg;
            end
        end
    end

    // Selects and address, launched with the true edge enable
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wsel_n_reg <= 1'b1;
            rsel_n_reg <= 1'b1;
            addr_reg <= '0;
            rd_ack_reg <= 1'b0;
            rd_skip_reg <= 1'b0;
        end else begin
            rd_ack_reg <= rd_issue;
            // Skip the next read slot: the memory is still bursting then
            if (rd_issue) begin
                rd_skip_reg <= 1'b1;
            end else if (true_next && t_par_reg) begin
                rd_skip_reg <= 1'b0;
            end
            if (edge_next) begin
                wsel_n_reg <= !wr_issue;
                rsel_n_reg <= !rd_issue;
            end
            if (wr_issue) begin
                addr_reg <= fifo_data[FW-1:BW];
            end else if (rd_issue) begin
                addr_reg <= rd_addr;
            end
        end
    end

    // Write beats: each word goes out on the same edge as its lane selects
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            be_n_reg <= '1;
            wdata_reg <= '0;
            burst_reg <= '0;
            beat_reg <= BEAT_FIRST;
            beat_on_reg <= 1'b0;
        end else if (wr_issue || beat_go) begin
            burst_reg <= burst_src;
            wdata_reg <= word_sel;
            be_n_reg <= be_sel;
            beat_reg <= beat_use + BEAT_STEP;
            beat_on_reg <= (beat_use != BEAT_LAST);
        end else if (edge_next) begin
            be_n_reg <= '1;
        end
    end

    // Read word capture one cycle after each edge while the memory drives
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_vld_reg <= 1'b0;
            rd_word_reg <= '0;
        end else begin
            rd_vld_reg <= edge_d_reg && !link.rdata_oe_n;
            if (edge_d_reg && !link.rdata_oe_n) begin
                rd_word_reg <= link.rdata;
            end
        end
    end
endmodule

// *** hdl/srp_mem_end.sv ***
`timescale 1ns/1ps
module srp_mem_end
    import srp_pkg::*;
#(
    parameter int DATA_W = DATA_W_X36,
    parameter int ADDR_W = (DATA_W == DATA_W_X18) ? ADDR_W_X18 : ADDR_W_X36
) (
    input wire logic clk_sys,
    input wire logic rstn,
    srp_if.memory link,
    output logic wr_busy,
    output logic rd_busy
);
    // Lane count follows the data width: two lanes for x18, four for x36
    localparam int NB = DATA_W / LANE_W;
    // Four words per address location
    localparam int IW = ADDR_W + BEAT_W;
    localparam int DEPTH = BURST_LEN << ADDR_W;

    // Write port state
    srp_wr_state_e wr_state_reg;
    srp_wr_state_e wr_state_next;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [1:0] wr_beat_reg;
    logic wr_busy_reg;

    // Read port state
    srp_rd_state_e rd_state_reg;
    srp_rd_state_e rd_state_next;
    logic [ADDR_W-1:0] rd_addr_reg;
    logic [1:0] rd_beat_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic rdata_oe_n_reg;
    logic rd_busy_reg;

    // Word read from the array at the current read beat
    wire [DATA_W-1:0] rd_word;

    // Edge qualifiers
    wire edge_any = link.k_rise || link.kn_rise;

    // Write start only on a true edge with the port chosen and idle
    wire wr_idle = (wr_state_reg == SRP_WR_IDLE);
    wire wr_in_burst = (wr_state_reg == SRP_WR_BURST);
    wire wr_start = link.k_rise && !link.write_port_choose_n && wr_idle;
    // Deselected idle port takes no data and no address; burst beats 1 to 3 are taken with the select high
    wire wr_beat_en = wr_start || (wr_in_burst && edge_any);
    wire [ADDR_W-1:0] wr_addr_use = wr_start ? link.addr : wr_addr_reg;
    wire [1:0] wr_beat_use = wr_start ? BEAT_FIRST : wr_beat_reg;
    wire [IW-1:0] wr_index = {wr_addr_use, wr_beat_use};
    wire wr_done = wr_in_burst && edge_any && (wr_beat_reg == BEAT_LAST);

    // Read start only on a true edge with the port chosen and idle
    wire rd_idle = (rd_state_reg == SRP_RD_IDLE);
    wire rd_waiting = (rd_state_reg == SRP_RD_WAIT);
    wire rd_in_burst = (rd_state_reg == SRP_RD_BURST);
    wire rd_start = link.k_rise && !link.read_port_choose_n && rd_idle;
    wire rd_drive = rd_in_burst && edge_any;
    wire rd_done = rd_drive && (rd_beat_reg == BEAT_LAST);
    wire [IW-1:0] rd_index = {rd_addr_reg, rd_beat_reg};

    // Next beat counts and busy levels
    wire [1:0] wr_beat_inc = wr_beat_use + BEAT_STEP;
    wire [1:0] rd_beat_inc = rd_beat_reg + BEAT_STEP;
    wire wr_busy_next = (wr_state_next == SRP_WR_BURST);
    wire rd_busy_next = (rd_state_next != SRP_RD_IDLE);

    // Output floats at the first edge with no burst word to drive
    wire rd_float = edge_any && (rd_idle || rd_waiting);

    assign link.rdata = rdata_reg;
    assign link.rdata_oe_n = rdata_oe_n_reg;
    assign wr_busy = wr_busy_reg;
    assign rd_busy = rd_busy_reg;

    // One array per 9-bit lane, written only when its select is low
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_lane
            logic [LANE_W-1:0] lane_mem [0:DEPTH-1];
            wire lane_we = wr_beat_en && !link.byte_lane_enable_n[gi];

            // Lane write; other lanes of the word stay untouched
            always_ff @(posedge clk_sys) begin
                if (lane_we) begin
                    lane_mem[wr_index] <= link.wdata[gi*LANE_W +: LANE_W];
                end
            end

            // Lane read for the output word
            assign rd_word[gi*LANE_W +: LANE_W] = lane_mem[rd_index];
        end
    endgenerate

    // Write sequencer next state
    always_comb begin
        wr_state_next = wr_state_reg;
        case (wr_state_reg)
            SRP_WR_IDLE: begin
                if (wr_start) begin
                    wr_state_next = SRP_WR_BURST;
                end
            end
            SRP_WR_BURST: begin
                if (wr_done) begin
                    wr_state_next = SRP_WR_IDLE;
                end
            end
            default: begin
                wr_state_next = SRP_WR_IDLE;
            end
        endcase
    end

    // Write sequencer registers: beat 0 at the true edge, beats 1 to 3 after
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_state_reg <= SRP_WR_IDLE;
            wr_addr_reg <= '0;
            wr_beat_reg <= BEAT_FIRST;
            wr_busy_reg <= 1'b0;
        end else begin
            wr_state_reg <= wr_state_next;
            wr_busy_reg <= wr_busy_next;
            if (wr_start) begin
                wr_addr_reg <= link.addr;
            end
            if (wr_beat_en) begin
                wr_beat_reg <= wr_beat_inc;
            end
        end
    end

    // Read sequencer next state
    always_comb begin
        rd_state_next = rd_state_reg;
        case (rd_state_reg)
            SRP_RD_IDLE: begin
                if (rd_start) begin
                    rd_state_next = SRP_RD_WAIT;
                end
            end
            SRP_RD_WAIT: begin
                if (link.kn_rise) begin
                    rd_state_next = SRP_RD_BURST;
                end
            end
            SRP_RD_BURST: begin
                if (rd_done) begin
                    rd_state_next = SRP_RD_IDLE;
                end
            end
            default: begin
                rd_state_next = SRP_RD_IDLE;
            end
        endcase
    end

    // Read sequencer registers and address capture
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_state_reg <= SRP_RD_IDLE;
            rd_addr_reg <= '0;
            rd_beat_reg <= BEAT_FIRST;
            rd_busy_reg <= 1'b0;
        end else begin
            rd_state_reg <= rd_state_next;
            rd_busy_reg <= rd_busy_next;
            if (rd_start) begin
                rd_addr_reg <= link.addr;
                rd_beat_reg <= BEAT_FIRST;
            end else if (rd_drive) begin
                rd_beat_reg <= rd_beat_inc;
            end
        end
    end

    // Output drivers: a word on every edge of the burst, float otherwise
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= '0;
            rdata_oe_n_reg <= 1'b1;
        end else if (rd_drive) begin
            rdata_reg <= rd_word;
            rdata_oe_n_reg <= 1'b0;
        end else if (rd_float) begin
            rdata_oe_n_reg <= 1'b1;
        end
    end
endmodule

// *** tb/srp_link_monitor.sv ***
`timescale 1ns/1ps
module srp_link_monitor #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 18
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic k_rise,
    input wire logic kn_rise,
    input wire logic write_port_choose_n,
    input wire logic read_port_choose_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W/9-1:0] byte_lane_enable_n,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic rdata_oe_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // Commands seen at a true edge slot
    sequence s_wr_cmd;
        k_rise && !write_port_choose_n;
    endsequence
    sequence s_rd_cmd;
        k_rise && !read_port_choose_n;
    endsequence

    // Selects only at true edges; slots alternate
    property p_wr_on_true;
        !write_port_choose_n |-> k_rise;
    endproperty
    property p_rd_on_true;
        !read_port_choose_n |-> k_rise;
    endproperty
    property p_true_then_comp;
        k_rise |=> kn_rise && !k_rise;
    endproperty
    property p_comp_then_true;
        kn_rise |=> k_rise && !kn_rise;
    endproperty
    // Burst timing of writes and reads
    property p_wr_burst;
        s_wr_cmd |=> write_port_choose_n [*3];
    endproperty
    property p_rd_words;
        s_rd_cmd |-> ##3 (!rdata_oe_n) [*4];
    endproperty
    property p_rd_float;
        s_rd_cmd ##4 read_port_choose_n |-> ##3 rdata_oe_n;
    endproperty
    property p_lanes_idle;
        s_wr_cmd ##4 write_port_choose_n |-> &byte_lane_enable_n;
    endproperty
    property p_drive_needs_read;
        $fell(rdata_oe_n) |-> !$past(read_port_choose_n, 3);
    endproperty

    a_wr_on_true: assert property (p_wr_on_true) else $error("write select off a true slot");
    a_rd_on_true: assert property (p_rd_on_true) else $error("read select off a true slot");
    a_true_then_comp: assert property (p_true_then_comp) else $error("no comp slot after true");
    a_comp_then_true: assert property (p_comp_then_true) else $error("no true slot after comp");
    a_wr_burst: assert property (p_wr_burst) else $error("write select inside burst");
    a_rd_words: assert property (p_rd_words) else $error("read words not driven");
    a_rd_float: assert property (p_rd_float) else $error("read bus not floated");
    a_lanes_idle: assert property (p_lanes_idle) else $error("lane selects active when idle");
    a_drive_needs_read: assert property (p_drive_needs_read) else $error("read bus driven without read");
endmodule

// *** tb/sram_port_select_byte_write_tb_top.sv ***
`timescale 1ns/1ps
module sram_port_select_byte_write_tb_top;
    import srp_pkg::*;
    localparam int DW = DATA_W_X36;
    localparam int AW = 6;
    localparam int NB = DW / LANE_W;
    localparam int BW = BURST_LEN * NB;
    logic clk_sys;
    logic rstn;
    logic wr_valid;
    logic wr_ready;
    logic [AW-1:0] wr_addr;
    logic [BURST_LEN*DW-1:0] wr_data;
    logic [BW-1:0] wr_be_n;
    logic rd_req;
    logic [AW-1:0] rd_addr;
    logic rd_ack;
    logic rd_word_valid;
    logic [DW-1:0] rd_word;
    logic wr_busy;
    logic rd_busy;
    logic [DW-1:0] shadow [0:(4<<AW)-1];
    int mismatches;
    int checks;
    bit st;
    bit stall;

    srp_if #(.DATA_W(DW), .ADDR_W(AW)) u_srp_if ();
    srp_ctl_end #(.DATA_W(DW), .ADDR_W(AW)) u_srp_ctl_end (.clk_sys(clk_sys), .rstn(rstn),
        .link(u_srp_if.controller), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_be_n(wr_be_n), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
        .rd_word_valid(rd_word_valid), .rd_word(rd_word));
    srp_mem_end #(.DATA_W(DW), .ADDR_W(AW)) u_srp_mem_end (.clk_sys(clk_sys), .rstn(rstn),
        .link(u_srp_if.memory), .wr_busy(wr_busy), .rd_busy(rd_busy));
    srp_link_monitor #(.DATA_W(DW), .ADDR_W(AW)) u_srp_link_monitor (.clk_sys(clk_sys), .rstn(rstn),
        .k_rise(u_srp_if.k_rise), .kn_rise(u_srp_if.kn_rise),
        .write_port_choose_n(u_srp_if.write_port_choose_n), .read_port_choose_n(u_srp_if.read_port_choose_n),
        .addr(u_srp_if.addr), .byte_lane_enable_n(u_srp_if.byte_lane_enable_n), .wdata(u_srp_if.wdata),
        .rdata(u_srp_if.rdata), .rdata_oe_n(u_srp_if.rdata_oe_n));

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Word pattern: every lane distinct per address, beat and pass
    function automatic logic [DW-1:0] pat(input int a, input int k, input int s);
        logic [DW-1:0] w;
        for (int i = 0; i < NB; i++) begin
            w[i*LANE_W+:LANE_W] = 9'((s % 2) * 256 + (a % 16) * 16 + k * 4 + i);
        end
        return w;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic timed_out();
        mismatches++;
        tally_and_finish();
    endtask

    // Push one burst; shadow keeps only lanes whose select is low
    task automatic push_write(input int a, input int s, input logic [BW-1:0] be, output bit stalled);
        int n;
        logic [DW-1:0] w;
        stalled = 0;
        @(posedge clk_sys);
        wr_valid <= 1'b1;
        wr_addr <= AW'(a);
        wr_be_n <= be;
        for (int k = 0; k < BURST_LEN; k++) begin
            w = pat(a, k, s);
            wr_data[k*DW+:DW] <= w;
            for (int i = 0; i < NB; i++) begin
                if (!be[k*NB+i]) shadow[a*4+k][i*LANE_W+:LANE_W] = w[i*LANE_W+:LANE_W];
            end
        end
        n = 0;
        do begin
            @(negedge clk_sys);
            if (wr_ready !== 1'b1) stalled = 1;
            if (++n > 200) timed_out();
        end while (wr_ready !== 1'b1);
        @(posedge clk_sys);
        wr_valid <= 1'b0;
    endtask

    // Read one burst and compare all four words
    task automatic read_check(input int a);
        int n;
        @(posedge clk_sys);
        rd_req <= 1'b1;
        rd_addr <= AW'(a);
        n = 0;
        do begin
            @(negedge clk_sys);
            if (++n > 200) timed_out();
        end while (rd_ack !== 1'b1);
        @(posedge clk_sys);
        rd_req <= 1'b0;
        for (int k = 0; k < BURST_LEN; k++) begin
            n = 0;
            do begin
                @(negedge clk_sys);
                if (++n > 50) timed_out();
            end while (rd_word_valid !== 1'b1);
            check(64'(rd_word), 64'(shadow[a*4+k]));
        end
    endtask

    task automatic wait_idle();
        int n;
        int q;
        repeat (4) @(posedge clk_sys);
        n = 0;
        q = 0;
        // Busy drops for a cycle between buffered bursts, so ask for a quiet run
        do begin
            @(negedge clk_sys);
            q = (wr_busy === 1'b0 && rd_busy === 1'b0) ? q + 1 : 0;
            if (++n > 200) timed_out();
        end while (q < 8);
        repeat (4) @(posedge clk_sys);
    endtask

    // Full burst written with every lane, then read back
    task automatic sc_full_burst();
        push_write(5, 0, '0, st);
        wait_idle();
        read_check(5);
    endtask

    // Lane masks per beat: one, alternate, none, all at address 5; then one lane per beat at 6, with 5 read back
    task automatic sc_lane_select();
        push_write(5, 1, {4'h0, 4'hF, 4'h5, 4'hE}, st);
        wait_idle();
        read_check(5);
        push_write(6, 1, {4'h7, 4'hB, 4'hD, 4'hE}, st);
        wait_idle();
        read_check(5);
    endtask

    // Back-to-back pushes fill the buffer, then drain into memory and are read back
    task automatic sc_buffer_fill();
        stall = 0;
        for (int a = 8; a < 18; a++) begin
            push_write(a, 0, '0, st);
            stall |= st;
        end
        check(64'(stall), 64'h1);
        wait_idle();
        for (int a = 8; a < 18; a++) begin
            read_check(a);
        end
    endtask

    // Idle link: read bus floats, ends idle
    task automatic sc_idle_float();
        wait_idle();
        check(64'(u_srp_if.rdata_oe_n), 64'h1);
        check(64'({wr_busy, rd_busy}), 64'h0);
    endtask

    initial begin
        rstn = 1'b0;
        wr_valid = 1'b0;
        wr_addr = '0;
        wr_data = '0;
        wr_be_n = '1;
        rd_req = 1'b0;
        rd_addr = '0;
        mismatches = 0;
        checks = 0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sc_full_burst();
        sc_lane_select();
        sc_buffer_fill();
        sc_idle_float();
        tally_and_finish();
    end
endmodule
